// File: rtl/sd_modulator_regs.svh
// constants and timing counts for the isolated delta-sigma bitstream block
// Summary of operation
// [R1] Bitstream output follows the external sample clock, run between 5 and 21 MHz.
// [R2] Average density of ones is proportional to the differential input.
// [R3] Second-order feed-forward modulator, 1-bit quantizer, feedback updated next cycle.
// [R4] Input chopper toggles at sample clock divided by 32.
// [R5] Linear, specified-noise operation only within plus or minus one volt.
// [R6] Plus or minus 1.25 volts is the modulator clipping level.
// [R7] Ones cross the barrier as carrier bursts, zeros as no carrier.
// [R8] The partner drives the sample clock continuously without pauses; the bench stops it for 120 clk cycles in t_freeze.
// [R9] Missing sample clock stops conversion and freezes the output level.
// [R10] Charge pump halts on slow or missing clock; bias current out of spec.
// [R11] After clock restart the partner discards data for the settle interval.
// [R12] The partner decimates the bitstream with a low-pass digital filter.
// [R13] Output changes on the sample clock rising edge; partner latches there.
// [R14] At or beyond full scale, one opposite bit every 128 output bits.
// [R15] Without the high-side supply, output is a steady stream of zeros.
// [R16] Partner allows 0.25 ms analog start-up after supply is applied.
// [R17] Input is a signed value sampled each clock and fed to the first integrator and the quantizer sum.
`ifndef SD_MODULATOR_REGS_SVH
`define SD_MODULATOR_REGS_SVH

// input codes: one volt is LINEAR_CODE, clipping at 1.25 V is CLIP_CODE
`define LINEAR_CODE           17'sd16000
`define CLIP_CODE             17'sd20000
`define MARKER_PERIOD         8'd128
`define CHOP_DIVIDE           6'd32

`define SYS_CLK_KHZ           40000
`define SAMPLE_CLK_MIN_KHZ    5000
`define SAMPLE_CLK_MAX_KHZ    21000
// longest gap between sample edges at the lowest legal rate, rounded down
`define MISS_GAP_CYCLES       (`SYS_CLK_KHZ / `SAMPLE_CLK_MIN_KHZ)

`define SYS_CLK_PERIOD_NS     25
`define SETTLE_TIME_NS        250000
`define SETTLE_CYCLES \
    ((`SETTLE_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// File: rtl/sd_modulator_pkg.sv
// types shared by the isolated delta-sigma bitstream block
package sd_modulator_pkg;
    typedef enum logic [1:0] {
        PUMP_OFF,
        PUMP_SETTLING,
        PUMP_RUN
    } pump_state_t;
endpackage

// File: rtl/ook_barrier_link.sv
// on-off keyed isolation channel: carrier bursts for ones, silence for zeros
`timescale 1ns/1ps
module ook_barrier_link (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic tx_bit,
    output logic      carrier_out,
    output logic      rx_bit
);
    logic carrier_reg;
    logic carrier_next;
    logic carrier_d_reg;
    logic carrier_d_next;
    logic rx_reg;
    logic rx_next;

    // the carrier is a toggle at clk rate; the real one is far faster
    always_comb begin
        carrier_next   = tx_bit ? ~carrier_reg : 1'b0; // [R7]
        carrier_d_next = carrier_reg;
        // envelope: any carrier activity in the last two cycles means one
        rx_next        = carrier_reg | carrier_d_reg; // [R7]
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carrier_reg   <= 1'b0;
            carrier_d_reg <= 1'b0;
            rx_reg        <= 1'b0;
        end else begin
            carrier_reg   <= carrier_next;
            carrier_d_reg <= carrier_d_next;
            rx_reg        <= rx_next;
        end
    end

    assign carrier_out = carrier_reg;
    assign rx_bit      = rx_reg;
endmodule // ook_barrier_link

// File: rtl/sd_bitstream_modulator.sv
// behavioural second-order delta-sigma modulator with fail-safe output
`timescale 1ns/1ps
`include "sd_modulator_regs.svh"
module sd_bitstream_modulator #(
    parameter int IN_W          = 16,
    parameter int INT_W         = 24,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           sample_clock_in,
    input  wire logic signed [IN_W-1:0]         pos_analog_in,
    input  wire logic signed [IN_W-1:0]         neg_analog_in,
    input  wire logic                           high_side_supply,
    output logic                                bitstream_out,
    output logic                                barrier_carrier,
    output logic                                chopper_phase,
    output logic                                pump_running,
    output logic                                bias_out_of_spec,
    output logic                                analog_settled,
    output logic                                in_linear_range,
    output sd_modulator_pkg::pump_state_t       pump_state
);
    import sd_modulator_pkg::*;

    localparam int GAP_W    = 8;
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

    logic                    clk_prev_reg;
    logic                    clk_prev_next;
    logic signed [INT_W-1:0] integ1_reg;
    logic signed [INT_W-1:0] integ1_next;
    logic signed [INT_W-1:0] integ2_reg;
    logic signed [INT_W-1:0] integ2_next;
    logic                    quant_reg;
    logic                    quant_next;
    logic                    tx_bit_reg;
    logic                    tx_bit_next;
    logic [6:0]              marker_cnt_reg;
    logic [6:0]              marker_cnt_next;
    logic [3:0]              chop_cnt_reg;
    logic [3:0]              chop_cnt_next;
    logic                    chop_reg;
    logic                    chop_next;
    logic [GAP_W-1:0]        gap_reg;
    logic [GAP_W-1:0]        gap_next;
    logic [SETTLE_W-1:0]     settle_reg;
    logic [SETTLE_W-1:0]     settle_next;
    pump_state_t             state_reg;
    pump_state_t             state_next;
    logic                    linear_reg;
    logic                    linear_next;
    logic                    pump_reg;
    logic                    pump_next;
    logic                    settled_reg;
    logic                    settled_next;
    logic                    rx_bit;
    logic                    carrier;

    logic                    rise;
    logic signed [IN_W:0]    diff;
    logic signed [IN_W:0]    x_in;
    logic signed [IN_W:0]    feedback;
    logic                    over_pos;
    logic                    over_neg;
    logic signed [INT_W+1:0] sum4;

    // integrator limiter keeps the loop recoverable after overdrive
    function automatic logic signed [INT_W-1:0] sat(
        input logic signed [INT_W+1:0] v
    );
        logic signed [INT_W+1:0] hi;
        logic signed [INT_W+1:0] lo;
        hi = (INT_W+2)'({1'b0, {(INT_W-1){1'b1}}});
        lo = -hi;
        if (v > hi) begin
            sat = hi[INT_W-1:0];
        end else if (v < lo) begin
            sat = lo[INT_W-1:0];
        end else begin
            sat = v[INT_W-1:0];
        end
    endfunction

    function automatic logic signed [INT_W+1:0] wide(
        input logic signed [IN_W:0] v
    );
        wide = (INT_W+2)'(v);
    endfunction

    // sample clock is a plain input sampled on clk; edges found by compare
    always_comb begin
        clk_prev_next = sample_clock_in;
        rise          = sample_clock_in & ~clk_prev_reg; // [R13]
    end

    // modulator datapath
    always_comb begin
        diff     = (IN_W+1)'(pos_analog_in) - (IN_W+1)'(neg_analog_in); // [R17]
        over_pos = diff >= `CLIP_CODE; // [R6]
        over_neg = diff <= -`CLIP_CODE; // [R6]
        if (over_pos) begin
            x_in = `CLIP_CODE;
        end else if (over_neg) begin
            x_in = -`CLIP_CODE;
        end else begin
            x_in = diff;
        end
        linear_next = (diff <= `LINEAR_CODE) && (diff >= -`LINEAR_CODE); // [R5]
        // feedback level comes from last cycle's decision
        feedback = quant_reg ? `CLIP_CODE : -`CLIP_CODE; // [R3]
        sum4 = (INT_W+2)'(integ2_reg) + (INT_W+2)'(integ1_reg)
             + wide(x_in); // [R3]
        integ1_next     = integ1_reg;
        integ2_next     = integ2_reg;
        quant_next      = quant_reg;
        tx_bit_next     = tx_bit_reg;
        marker_cnt_next = marker_cnt_reg;
        if (!high_side_supply) begin
            // fail-safe: steady zeros, no markers, loop cleared
            integ1_next     = '0; // [R15]
            integ2_next     = '0;
            quant_next      = 1'b0;
            tx_bit_next     = 1'b0; // [R15]
            marker_cnt_next = '0;
        end else if (rise) begin // [R1] [R9]
            integ1_next = sat((INT_W+2)'(integ1_reg)
                        + wide(x_in) - wide(feedback)); // [R2] [R17]
            integ2_next = sat((INT_W+2)'(integ2_reg)
                        + (INT_W+2)'(integ1_reg)); // [R3]
            quant_next  = (sum4 >= 0); // [R3]
            if (over_pos || over_neg) begin
                marker_cnt_next = marker_cnt_reg + 7'd1;
                // one opposite bit per 128 so the partner sees a live part
                if (marker_cnt_reg == 7'(`MARKER_PERIOD - 8'd1)) begin
                    tx_bit_next = over_neg; // [R14]
                end else begin
                    tx_bit_next = over_pos; // [R14]
                end
            end else begin
                marker_cnt_next = '0;
                tx_bit_next     = quant_next; // [R2]
            end
        end
    end

    // chopper: half period of 16 edges gives a square wave at fs/32
    always_comb begin
        chop_cnt_next = chop_cnt_reg;
        chop_next     = chop_reg;
        if (rise) begin
            chop_cnt_next = chop_cnt_reg + 4'd1;
            if (chop_cnt_reg == 4'(`CHOP_DIVIDE / 6'd2 - 6'd1)) begin
                chop_next = ~chop_reg; // [R4]
            end
        end
    end

    // clock presence, charge pump and bias settling
    always_comb begin
        if (rise) begin
            gap_next = '0;
        end else if (gap_reg != '1) begin
            gap_next = gap_reg + GAP_W'(1);
        end else begin
            gap_next = gap_reg;
        end
        state_next  = state_reg;
        settle_next = settle_reg;
        unique case (state_reg)
            PUMP_OFF: begin
                settle_next = '0;
                if (high_side_supply && rise) begin
                    state_next = PUMP_SETTLING; // [R11]
                end
            end
            PUMP_SETTLING: begin
                settle_next = settle_reg + SETTLE_W'(1);
                if (settle_reg == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                    state_next = PUMP_RUN; // [R16]
                end
            end
            PUMP_RUN: begin
                settle_next = '0;
            end
        endcase
        // gap longer than the slowest legal period: pump stops
        if (!high_side_supply || gap_next > GAP_W'(`MISS_GAP_CYCLES)) begin
            state_next  = PUMP_OFF; // [R10]
            settle_next = '0;
        end
        pump_next    = (state_next != PUMP_OFF); // [R10]
        settled_next = (state_next == PUMP_RUN); // [R11]
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_prev_reg   <= 1'b0;
            integ1_reg     <= '0;
            integ2_reg     <= '0;
            quant_reg      <= 1'b0;
            tx_bit_reg     <= 1'b0;
            marker_cnt_reg <= '0;
            chop_cnt_reg   <= '0;
            chop_reg       <= 1'b0;
            gap_reg        <= '1;
            settle_reg     <= '0;
            state_reg      <= PUMP_OFF;
            linear_reg     <= 1'b0;
            pump_reg       <= 1'b0;
            settled_reg    <= 1'b0;
        end else begin
            clk_prev_reg   <= clk_prev_next;
            integ1_reg     <= integ1_next;
            integ2_reg     <= integ2_next;
            quant_reg      <= quant_next;
            tx_bit_reg     <= tx_bit_next;
            marker_cnt_reg <= marker_cnt_next;
            chop_cnt_reg   <= chop_cnt_next;
            chop_reg       <= chop_next;
            gap_reg        <= gap_next;
            settle_reg     <= settle_next;
            state_reg      <= state_next;
            linear_reg     <= linear_next;
            pump_reg       <= pump_next;
            settled_reg    <= settled_next;
        end
    end

    // bit crosses the barrier before reaching the output pin
    ook_barrier_link u_link (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .tx_bit      (tx_bit_reg),
        .carrier_out (carrier),
        .rx_bit      (rx_bit)
    );

    assign bitstream_out    = rx_bit;
    assign barrier_carrier  = carrier;
    assign chopper_phase    = chop_reg;
    assign pump_running     = pump_reg;
    assign bias_out_of_spec = ~pump_reg;
    assign analog_settled   = settled_reg;
    assign in_linear_range  = linear_reg;
    assign pump_state       = state_reg;
endmodule // sd_bitstream_modulator

// File: tb/sd_checker.sv
// port-level assertions for the bitstream modulator
`timescale 1ns/1ps
module sd_checker #(
    parameter int IN_W          = 16,
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic                          clk,
    input wire logic                          sys_rst,
    input wire logic                          sample_clock_in,
    input wire logic signed [IN_W-1:0]        pos_analog_in,
    input wire logic signed [IN_W-1:0]        neg_analog_in,
    input wire logic                          high_side_supply,
    input wire logic                          bitstream_out,
    input wire logic                          barrier_carrier,
    input wire logic                          pump_running,
    input wire logic                          bias_out_of_spec,
    input wire logic                          in_linear_range,
    input wire sd_modulator_pkg::pump_state_t pump_state
);
    import sd_modulator_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic signed [IN_W:0] diff;
    logic                 lin_reg;
    int                   settle_reg;
    assign diff = pos_analog_in - neg_analog_in;
    always_ff @(posedge clk) begin
        lin_reg <= (diff <= 17'sh3e80) && (diff >= -17'sh3e80);
        settle_reg <= (pump_state == PUMP_SETTLING) ? settle_reg + 1 : 0;
    end
    sequence carrier_quiet;
        !barrier_carrier [*2];
    endsequence
    sequence no_sample_edge;
        (high_side_supply && $stable(sample_clock_in)) [*4];
    endsequence
    a_quiet_to_zero: assert property (carrier_quiet |=> !bitstream_out)
        else $error("output high without carrier");
    a_supply_zero: assert property (!high_side_supply [*4] |-> !bitstream_out)
        else $error("output high with supply missing");
    a_bias_flag: assert property (bias_out_of_spec == !pump_running)
        else $error("bias flag disagrees with pump");
    a_frozen_out: assert property (no_sample_edge |=> $stable(bitstream_out))
        else $error("output moved without sample clock");
    a_gap_pump_off: assert property ($stable(sample_clock_in) [*8] ##1
        $stable(sample_clock_in) [*3] |-> ##[0:2] pump_state == PUMP_OFF)
        else $error("pump kept running without clock");
    a_supply_pump: assert property (!high_side_supply |=> pump_state == PUMP_OFF)
        else $error("pump running without supply");
    a_lin_flag: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
        |-> in_linear_range == lin_reg)
        else $error("linear range flag wrong");
    a_settle_span: assert property (pump_state == PUMP_RUN &&
        $past(pump_state) == PUMP_SETTLING |-> settle_reg
        inside {[SETTLE_CYCLES-1:SETTLE_CYCLES+1]})
        else $error("settle interval wrong length");
endmodule // sd_checker
bind sd_bitstream_modulator sd_checker #(.IN_W(IN_W),
    .SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.clk(clk), .sys_rst(sys_rst),
    .sample_clock_in(sample_clock_in), .pos_analog_in(pos_analog_in),
    .neg_analog_in(neg_analog_in), .high_side_supply(high_side_supply),
    .bitstream_out(bitstream_out), .barrier_carrier(barrier_carrier),
    .pump_running(pump_running), .bias_out_of_spec(bias_out_of_spec),
    .in_linear_range(in_linear_range), .pump_state(pump_state));

// File: tb/filter_partner.sv
// decimation-side partner: makes the sample clock, latches the bitstream
`timescale 1ns/1ps
module filter_partner (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic bit_in,
    output logic      sample_clock_in,
    output logic      bit_taken,
    output logic      taken_pulse
);
    logic [1:0] phase_reg = 2'h0;
    initial sample_clock_in = 1'b0;
    initial bit_taken = 1'b0;
    initial taken_pulse = 1'b0;
    // four clk per period is 10 MHz; clock stands still while run is low
    always @(negedge clk) begin
        taken_pulse <= 1'b0;
        if (run) begin
            phase_reg <= phase_reg + 2'h1;
            sample_clock_in <= phase_reg[1];
            if (phase_reg == 2'h2) begin
                bit_taken <= bit_in;
                taken_pulse <= 1'b1;
            end
        end
    end
endmodule // filter_partner

// File: tb/tb.sv
// self-checking bench for the delta-sigma bitstream block
`timescale 1ns/1ps
module tb;
    import sd_modulator_pkg::*;
    localparam int SETTLE = 20;
    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               run = 1'b0;
    logic               supply = 1'b1;
    logic signed [15:0] pos_in = 16'sh0000;
    logic signed [15:0] neg_in = 16'sh0000;
    logic               sclk, taken, pulse, bits, carrier, chop;
    logic               pump, bias, settled, lin;
    pump_state_t        pstate;
    int                 err_total = 0, samples_checked = 0, cycles = 0;
    int                 ones, takes, chops;
    always #12.5 clk = ~clk;
    sd_bitstream_modulator #(.SETTLE_CYCLES(SETTLE)) dut_u (.clk(clk),
        .sys_rst(sys_rst), .sample_clock_in(sclk), .pos_analog_in(pos_in),
        .neg_analog_in(neg_in), .high_side_supply(supply),
        .bitstream_out(bits), .barrier_carrier(carrier),
        .chopper_phase(chop), .pump_running(pump), .bias_out_of_spec(bias),
        .analog_settled(settled), .in_linear_range(lin),
        .pump_state(pstate));
    filter_partner part_u (.clk(clk), .run(run), .bit_in(bits),
        .sample_clock_in(sclk), .bit_taken(taken), .taken_pulse(pulse));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic set_in(input logic signed [15:0] p, input logic signed [15:0] n);
        @(negedge clk);
        pos_in = p;
        neg_in = n;
    endtask
    // counts latched ones and chopper flips over n sample periods
    task automatic window(input int n);
        logic last;
        ones = 0; takes = 0; chops = 0; last = chop;
        while (takes < n) begin
            @(posedge clk);
            if (pulse === 1'b1) begin
                takes++;
                ones += (taken === 1'b1);
            end
            chops += (chop !== last);
            last = chop;
        end
    endtask
    task automatic t_density();
        logic signed [15:0] p[3] = '{16'sh0000, 16'sh3e80, 16'sh0000};
        logic signed [15:0] n[3] = '{16'sh0000, 16'sh0000, 16'sh3e80};
        int ex[3] = '{128, 230, 26};
        for (int i = 0; i < 3; i++) begin
            set_in(p[i], n[i]);
            window(64);
            window(256);
            check(ones > ex[i] - 16 && ones < ex[i] + 16, 1);
            check(chops, 16);
            check(lin, 1);
        end
    endtask
    task automatic t_clip();
        set_in(16'sh4e20, 16'sh0000);
        window(200);
        window(256);
        check(ones, 254);
        check(lin, 0);
        set_in(16'sh0000, 16'sh4e20);
        window(200);
        window(256);
        check(ones, 2);
    endtask
    task automatic t_freeze();
        logic held;
        set_in(16'sh4e20, 16'sh0000);
        window(40);
        run = 1'b0;
        repeat (20) @(posedge clk);
        held = bits;
        set_in(16'sh0000, 16'sh4e20);
        repeat (100) @(posedge clk);
        check(bits, held);
        check(bias, 1);
        check(pump, 0);
        @(negedge clk);
        run = 1'b1;
        repeat (8) @(posedge clk);
        check(settled, 0);
        repeat (SETTLE + 16) @(posedge clk);
        check(settled, 1);
    endtask
    task automatic t_supply();
        @(negedge clk);
        supply = 1'b0;
        window(8);
        window(300);
        check(ones, 0);
        check(pstate, PUMP_OFF);
        @(negedge clk);
        supply = 1'b1;
        repeat (SETTLE + 60) @(posedge clk);
        check(settled, 1);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        run = 1'b1;
        check(pstate, PUMP_OFF);
        repeat (SETTLE + 20) @(posedge clk);
        check(settled, 1);
        t_density();
        t_clip();
        t_freeze();
        t_supply();
        conclude();
    end
    // ceiling well above the roughly 9200 cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            conclude();
        end
    end
endmodule // tb
